// file: inc/adcc_pkg.sv
// Package for the converter control block: register addresses, field
// positions, reset values and timing counts.
// Assumes an 8-bit special function register bus from the CPU core.
`default_nettype none
package adcc_pkg;
    localparam logic [7:0] ADCC_ADDR_CLKDIV   = 8'hF2;
    localparam logic [7:0] ADCC_ADDR_CONTROL  = 8'hF3;
    localparam logic [7:0] ADCC_ADDR_RES_LOW  = 8'hF4;
    localparam logic [7:0] ADCC_ADDR_RES_HIGH = 8'hF5;
    // Control register bit positions.
    localparam int ADCC_CTL_CHSEL = 0;
    localparam int ADCC_CTL_START = 3;
    localparam int ADCC_CTL_DONE  = 4;
    localparam int ADCC_CTL_EN    = 5;
    localparam int ADCC_CTL_IDLE  = 6;
    // Writable bits of the control and divider registers; the rest read as zero.
    localparam logic [7:0] ADCC_CTL_MASK    = 8'h79;
    localparam logic [7:0] ADCC_CLKDIV_MASK = 8'h1F;
    localparam logic [7:0] ADCC_RESET_VALUE = 8'h00;
    // Divider field width and the value that zero stands for.
    localparam int         ADCC_DIV_W    = 5;
    localparam logic [5:0] ADCC_DIV_ZERO = 6'h20;
    localparam int         ADCC_RES_W    = 10;
    // Converter clock periods per conversion.
    localparam logic [3:0] ADCC_CONV_PERIODS = 4'hB;
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_CONVERT} adcc_state_t;
endpackage
`default_nettype wire

// file: inc/adcc_tick_if.sv
// Interface carrying the converter clock enable and its divider setting.
// Assumes both ends sit on the same system clock.
`default_nettype none
interface adcc_tick_if;
    import adcc_pkg::*;
    logic [ADCC_DIV_W-1:0] divide;   // Divider field value.
    logic                  run;      // Divider active.
    logic                  tick;     // One pulse per converter period.
    modport gen (input divide, input run, output tick);
    modport use_ (output divide, output run, input tick);
endinterface
`default_nettype wire

// file: core/adcc_clkdiv.sv
// Converter clock divider producing a one-cycle enable per period.
// Assumes the peripheral clock is the module clock.
`default_nettype none
module adcc_clkdiv
    import adcc_pkg::*;
(
    input  wire logic   clk,   // Peripheral clock.
    input  wire logic   rst,   // Synchronous reset, active high.
    adcc_tick_if.gen    tk     // Divider setting and tick.
);
    logic [5:0] cnt_q;
    logic [5:0] period;

    // Zero divides like thirty-two.
    assign period = (tk.divide == '0) ? ADCC_DIV_ZERO
                                      : {1'b0, tk.divide};

    // Count peripheral clocks and pulse once per period.
    always_ff @(posedge clk)
    begin
        if (rst || !tk.run)
        begin
            cnt_q   <= 6'h00;
            tk.tick <= 1'b0;
        end
        else if (cnt_q + 6'h01 >= period)
        begin
            cnt_q   <= 6'h00;
            tk.tick <= 1'b1;
        end
        else
        begin
            cnt_q   <= cnt_q + 6'h01;
            tk.tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: core/adcc_top.sv
// Converter control: registers, conversion sequencing and CPU stall.
// Assumes an 8-bit register bus and an external comparator/DAC result.
`default_nettype none
module adcc_top
    import adcc_pkg::*;
(
    input  wire logic                  clk,          // Peripheral clock.
    input  wire logic                  rst,          // Sync reset, high.
    input  wire logic [7:0]            reg_addr,     // Register address.
    input  wire logic                  reg_wr,       // Write strobe.
    input  wire logic                  reg_rd,       // Read strobe.
    input  wire logic [7:0]            reg_wdata,    // Write data.
    output logic      [7:0]            reg_rdata,    // Read data.
    input  wire logic                  conversion_irq_enable, // Irq enable.
    input  wire logic [ADCC_RES_W-1:0] conversion_result_in, // Analog code.
    output logic                       channel_select,  // 1 = input zero.
    output logic                       sample_hold,     // Sample strobe.
    output logic                       converter_power, // Analog enable.
    output logic                       cpu_stall,       // Freeze the core.
    output logic                       conversion_irq   // Interrupt request.
);
    adcc_tick_if tk ();

    // Register state: one flop group for each field of the control byte,
    // so that the set, clear and write rules of each field stand apart.
    // The byte that software reads is put together from them below.
    logic                  chsel_q;     // Channel select bit.
    logic                  start_q;     // Start and status bit.
    logic                  done_q;      // End-of-conversion flag.
    logic                  enable_q;    // Converter enable bit.
    logic                  idle_q;      // Pseudo-idle select bit.
    logic                  stall_q;     // Core stall for this conversion.
    logic [7:0]            clkdiv_q;    // Divider register.
    logic [ADCC_RES_W-1:0] result_q;    // Last conversion result.
    logic [ADCC_RES_W-1:0] sync1_q;     // First synchroniser stage.
    logic [ADCC_RES_W-1:0] sync2_q;     // Second synchroniser stage.
    logic [3:0]            periods_q;   // Converter periods elapsed.
    adcc_state_t           state_q;     // Sequencer state.

    // Decoded strobes and status shared by several processes; all of
    // them are combinational and settle within the bus cycle.
    logic [7:0]            ctl_byte;    // Control byte as read back.
    logic                  converting;  // A conversion is running.
    logic                  ctl_wr;      // Write to the control byte.
    logic                  div_wr;      // Write to the divider byte.
    logic                  start_wr;    // Accepted launch request.
    logic                  abort;       // Enable cleared mid-conversion.
    logic                  last_period; // Counter is in its last period.
    logic                  finish;      // Last converter period ends.

    // True when a bus strobe is raised for the given register address.
    // Used for every write decode so that all of them match exactly.
    function automatic logic adcc_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return strobe && (addr == target);
    endfunction

    // Split the ten-bit result into one of its two bus bytes; the low
    // byte keeps its unused upper bits at zero.
    function automatic logic [7:0] adcc_result_byte(
        input logic [ADCC_RES_W-1:0] value,
        input logic                  high
    );
        return high ? value[ADCC_RES_W-1:2] : {6'h00, value[1:0]};
    endfunction

    // Divider instance clocked by the peripheral clock. It hands back a
    // one-cycle enable per converter period, never a derived clock.
    adcc_clkdiv u_div (
        .clk (clk),
        .rst (rst),
        .tk  (tk.gen)
    );

    // The divider only runs while a conversion is in progress, so each
    // conversion starts with a full first converter period.
    assign tk.divide = clkdiv_q[ADCC_DIV_W-1:0];
    assign tk.run    = converting;

    // Decode register writes and the conversion end. A start is taken
    // only from idle and only when the same write keeps the converter
    // enabled; a start written while a conversion runs changes nothing.
    assign converting  = (state_q == ADCC_CONVERT);
    assign ctl_wr      = adcc_hit(reg_wr, reg_addr, ADCC_ADDR_CONTROL);
    assign div_wr      = adcc_hit(reg_wr, reg_addr, ADCC_ADDR_CLKDIV);
    assign start_wr    = ctl_wr && !converting
                         && reg_wdata[ADCC_CTL_START]
                         && reg_wdata[ADCC_CTL_EN];
    assign abort       = ctl_wr && converting && !reg_wdata[ADCC_CTL_EN];
    assign last_period = (periods_q == ADCC_CONV_PERIODS - 4'h1);
    assign finish      = converting && tk.tick && last_period;

    // Analog result arrives from outside the clock domain. The sample-
    // and-hold keeps the code still after the first converter period, so a plain
    // two-stage synchroniser per bit is enough here.
    always_ff @(posedge clk)
    begin
        sync1_q <= conversion_result_in;
        sync2_q <= sync1_q;
    end

    // Divider register; reserved bits are kept clear. A new value
    // also changes the length of the period now being counted.
    always_ff @(posedge clk)
    begin
        if (rst)
            clkdiv_q <= ADCC_RESET_VALUE;
        else if (div_wr)
            clkdiv_q <= reg_wdata & ADCC_CLKDIV_MASK;
    end

    // Channel select bit, written freely by software. A change after the
    // first converter period of a conversion only matters for the next sample.
    always_ff @(posedge clk)
    begin
        if (rst)
            chsel_q <= ADCC_RESET_VALUE[ADCC_CTL_CHSEL];
        else if (ctl_wr)
            chsel_q <= reg_wdata[ADCC_CTL_CHSEL];
    end

    // Enable bit. Clearing it puts the analog part into standby and
    // also stops a running conversion.
    always_ff @(posedge clk)
    begin
        if (rst)
            enable_q <= ADCC_RESET_VALUE[ADCC_CTL_EN];
        else if (ctl_wr)
            enable_q <= reg_wdata[ADCC_CTL_EN];
    end

    // Start bit: set by an accepted launch, held while the conversion
    // runs and cleared by hardware at its end or when it is aborted, so
    // it never sticks. A start written without the enable bit never sets it.
    always_ff @(posedge clk)
    begin
        if (rst)
            start_q <= ADCC_RESET_VALUE[ADCC_CTL_START];
        else if (finish || abort)
            start_q <= 1'b0;
        else if (start_wr)
            start_q <= 1'b1;
    end

    // Done flag: set by hardware, written by software. A conversion end
    // in the same cycle as a software clear wins, so no result is lost.
    always_ff @(posedge clk)
    begin
        if (rst)
            done_q <= ADCC_RESET_VALUE[ADCC_CTL_DONE];
        else if (finish)
            done_q <= 1'b1;
        else if (ctl_wr)
            done_q <= reg_wdata[ADCC_CTL_DONE];
    end

    // Pseudo-idle select bit, cleared by hardware at conversion end.
    // The clear wins over a write in the same cycle.
    always_ff @(posedge clk)
    begin
        if (rst)
            idle_q <= ADCC_RESET_VALUE[ADCC_CTL_IDLE];
        else if (finish)
            idle_q <= 1'b0;
        else if (ctl_wr)
            idle_q <= reg_wdata[ADCC_CTL_IDLE];
    end

    // Core stall: armed only by a launch that carries the pseudo-idle
    // bit, so setting that bit in mid-conversion does not freeze the
    // core part way. It ends with the conversion or an abort.
    always_ff @(posedge clk)
    begin
        if (rst)
            stall_q <= ADCC_RESET_VALUE[ADCC_CTL_IDLE];
        else if (finish || abort)
            stall_q <= 1'b0;
        else if (start_wr)
            stall_q <= reg_wdata[ADCC_CTL_IDLE];
    end

    // Conversion sequencer: idle until a launch, then converting until
    // the last converter period ends or the converter is disabled. The
    // start, stall and counter flops all follow its two states.
    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= ADCC_IDLE;
        else
        begin
            case (state_q)
                ADCC_IDLE:
                begin
                    if (start_wr)
                        state_q <= ADCC_CONVERT;
                end
                ADCC_CONVERT:
                begin
                    if (abort)
                        state_q <= ADCC_IDLE;
                    else if (finish)
                        state_q <= ADCC_IDLE;
                end
                default:
                    state_q <= ADCC_IDLE;
            endcase
        end
    end

    // Converter period counter; it restarts from zero whenever the
    // sequencer is idle, so an aborted conversion leaves nothing behind
    // for the next launch.
    always_ff @(posedge clk)
    begin
        if (rst || !converting)
            periods_q <= 4'h0;
        else if (tk.tick)
            periods_q <= periods_q + 4'h1;
    end

    // Result capture at conversion end; an abort keeps the old result
    // so that a cut conversion never shows a half-made code.
    always_ff @(posedge clk)
    begin
        if (rst)
            result_q <= '0;
        else if (finish)
            result_q <= sync2_q;
    end

    // Control byte as software reads it; reserved bits stay zero
    // because they start from the all-zero value and no flop sits
    // behind them.
    always_comb
    begin
        ctl_byte                 = ADCC_RESET_VALUE;
        ctl_byte[ADCC_CTL_CHSEL] = chsel_q;
        ctl_byte[ADCC_CTL_START] = start_q;
        ctl_byte[ADCC_CTL_DONE]  = done_q;
        ctl_byte[ADCC_CTL_EN]    = enable_q;
        ctl_byte[ADCC_CTL_IDLE]  = idle_q;
    end

    // Read multiplexer; the result registers ignore writes. Reads have
    // no side effects, and an idle strobe or an unmapped address
    // returns zero.
    always_comb
    begin
        reg_rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ADCC_ADDR_CLKDIV:   reg_rdata = clkdiv_q;
                ADCC_ADDR_CONTROL:  reg_rdata = ctl_byte;
                ADCC_ADDR_RES_LOW:
                    reg_rdata = adcc_result_byte(result_q, 1'b0);
                ADCC_ADDR_RES_HIGH:
                    reg_rdata = adcc_result_byte(result_q, 1'b1);
                default:            reg_rdata = 8'h00;
            endcase
        end
    end

    // Analog side controls: channel bit, power and sample strobe. The
    // sample-and-hold follows its input for the first converter period
    // and holds the level for the rest of the conversion.
    assign channel_select  = chsel_q;
    assign converter_power = enable_q;
    assign sample_hold     = converting && (periods_q == 4'h0);

    // Stall only the core; peripherals keep their clock, and interrupts
    // raised meanwhile stay pending at the core until the stall drops.
    // Nothing here masks or drops an interrupt source.
    assign cpu_stall = stall_q;

    // Interrupt request follows the done flag through its enable; both
    // are levels, so the request holds until the flag is cleared.
    assign conversion_irq = done_q && conversion_irq_enable;
endmodule
`default_nettype wire

// file: verification/adcc_analog_model.sv
// Model of the two analog inputs behind the sample-and-hold.
// Assumes the block samples the code once the conversion ends.
`default_nettype none
module adcc_analog_model
    import adcc_pkg::*;
(
    input  wire logic                  clk,               // Clock.
    input  wire logic                  sel,               // Channel bit.
    input  wire logic                  hold,              // Sample strobe.
    input  wire logic [ADCC_RES_W-1:0] analog_input_zero, // Input zero.
    input  wire logic [ADCC_RES_W-1:0] analog_input_one,  // Input one.
    output logic      [ADCC_RES_W-1:0] code               // Comparator code.
);
    // Capture the selected ten-bit level while sampling, then hold it.
    always_ff @(posedge clk)
    begin
        if (hold)
        begin
            code <= sel ? analog_input_zero : analog_input_one;
        end
    end
endmodule
`default_nettype wire

// file: verification/adcc_asserts.sv
// Checker for the converter control block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module adcc_asserts
    import adcc_pkg::*;
(
    input wire logic       clk,                   // Clock.
    input wire logic       rst,                   // Reset.
    input wire logic [7:0] reg_addr,              // Address.
    input wire logic       reg_wr,                // Write strobe.
    input wire logic       reg_rd,                // Read strobe.
    input wire logic [7:0] reg_wdata,             // Write data.
    input wire logic [7:0] reg_rdata,             // Read data.
    input wire logic       conversion_irq_enable, // Irq enable.
    input wire logic       channel_select,        // Channel bit.
    input wire logic       converter_power,       // Enable bit.
    input wire logic       cpu_stall,             // Core stall.
    input wire logic       conversion_irq         // Irq request.
);
    // All properties share the clock and the reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_rc;
        reg_rd && reg_addr == ADCC_ADDR_CONTROL |->
            (reg_rdata & ~ADCC_CTL_MASK) == 8'h00;
    endproperty
    a_rc: assert property (p_rc) else $error("Control bit stuck.");
    property p_rd;
        reg_rd && reg_addr == ADCC_ADDR_CLKDIV |-> reg_rdata[7:5] == 3'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("Divider bit stuck.");
    property p_rl;
        reg_rd && reg_addr == ADCC_ADDR_RES_LOW |-> reg_rdata[7:2] == 6'h00;
    endproperty
    a_rl: assert property (p_rl) else $error("Low byte bad.");
    property p_irq;
        conversion_irq |-> conversion_irq_enable;
    endproperty
    a_irq: assert property (p_irq) else $error("Irq unmasked.");
    property p_wr;
        reg_wr && reg_addr == ADCC_ADDR_CONTROL |=> converter_power ==
            $past(reg_wdata[5]) && channel_select == $past(reg_wdata[0]);
    endproperty
    a_wr: assert property (p_wr) else $error("Control lost.");
    property p_st;
        $rose(cpu_stall) |-> $past(reg_wr) && $past(reg_wdata[6]);
    endproperty
    a_st: assert property (p_st) else $error("Stray stall.");
    property p_sd;
        $rose(cpu_stall) |-> cpu_stall[*8] ##[1:400] !cpu_stall;
    endproperty
    a_sd: assert property (p_sd) else $error("Stall span.");
    property p_if;
        $fell(conversion_irq) |-> $past(reg_wr) || !conversion_irq_enable;
    endproperty
    a_if: assert property (p_if) else $error("Flag lost.");
endmodule
bind adcc_top adcc_asserts u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .conversion_irq_enable, .channel_select,
    .converter_power, .cpu_stall, .conversion_irq);
`default_nettype wire

// file: verification/adc_conversion_control_test.sv
// Self-checking bench for the converter control block.
// Assumes the analog model and the checker are compiled before it.
`default_nettype none
module adc_conversion_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import adcc_pkg::*;
    logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic        conversion_irq_enable = 0;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [9:0]  lvl0 = 10'h000, lvl1 = 10'h000, conversion_result_in;
    logic        channel_select, sample_hold, converter_power;
    logic        cpu_stall, conversion_irq;
    logic [15:0] lf = 16'h020E;
    int          n_errors = 0, compares = 0, m_ctl = 0;
    adcc_top dut (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .conversion_irq_enable, .conversion_result_in,
        .channel_select, .sample_hold, .converter_power, .cpu_stall,
        .conversion_irq);
    adcc_analog_model u_ain (.clk, .sel(channel_select), .hold(sample_hold),
        .analog_input_zero(lvl0), .analog_input_one(lvl1),
        .code(conversion_result_in));
    initial forever #25 clk = ~clk;
    // Shared byte comparison.
    task automatic chk(input logic [7:0] g, e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // One write strobe; the model follows control writes.
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        if (a == ADCC_ADDR_CONTROL)
        begin
            m_ctl = d[5] ? d & 8'h79 : d & 8'h71;
        end
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        #1 chk(reg_rdata, e);
        @(negedge clk);
        reg_rd = 0;
    endtask
    // A full conversion, polled through the start bit.
    task automatic conv(input logic ch, id, ie, input logic [4:0] n);
        int c, lo;
        logic [9:0] r;
        wr(ADCC_ADDR_CLKDIV, {3'h0, n});
        wr(ADCC_ADDR_CONTROL, {3'h1, 4'h0, ch});
        repeat (8) @(negedge clk);
        lvl0 = lf[9:0];
        lf = lfsr(lf);
        lvl1 = lf[9:0];
        lf = lfsr(lf);
        conversion_irq_enable = ie;
        r = ch ? lvl0 : lvl1;
        lo = (n == 5'h00) ? 32 : int'(n);
        wr(ADCC_ADDR_CONTROL, {1'b0, id, 4'hA, 1'b0, ch});
        reg_rd = 1;
        c = 0;
        #1;
        while (reg_rdata[3] === 1'b1 && c < 2000)
        begin
            chk(8'(cpu_stall), 8'(id));
            c++;
            @(negedge clk);
            #1;
        end
        reg_rd = 0;
        chk(8'(c >= 10 * lo && c <= 11 * lo + 3), 8'h01);
        m_ctl = (m_ctl & 8'h21) | 8'h10;
        rdc(ADCC_ADDR_CONTROL, 8'(m_ctl));
        rdc(ADCC_ADDR_RES_HIGH, r[9:2]);
        rdc(ADCC_ADDR_RES_LOW, {6'h00, r[1:0]});
        chk(8'(conversion_irq), 8'(ie));
        wr(ADCC_ADDR_CONTROL, {3'h1, 4'h0, ch});
        chk(8'(conversion_irq), 8'h00);
    endtask
    task automatic finish_test;
        $display("Compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence: reset values, access kinds, then conversions.
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 0;
        for (int a = 8'hF2; a <= 8'hF6; a++) rdc(8'(a), 8'h00);
        wr(ADCC_ADDR_CLKDIV, 8'hFF);
        rdc(ADCC_ADDR_CLKDIV, 8'h1F);
        wr(ADCC_ADDR_CONTROL, 8'h87);
        rdc(ADCC_ADDR_CONTROL, 8'h01);
        wr(ADCC_ADDR_RES_HIGH, 8'hFF);
        wr(ADCC_ADDR_RES_LOW, 8'hFF);
        rdc(ADCC_ADDR_RES_HIGH, 8'h00);
        rdc(ADCC_ADDR_RES_LOW, 8'h00);
        wr(ADCC_ADDR_CONTROL, 8'h08);
        rdc(ADCC_ADDR_CONTROL, 8'h00);
        for (int i = 0; i < 4; i++) conv(i[0], i[1], !i[0], 5'(i * i));
        // Launch, then abort by clearing enable: start drops, no done.
        wr(ADCC_ADDR_CONTROL, 8'h28);
        rdc(ADCC_ADDR_CONTROL, 8'h28);
        wr(ADCC_ADDR_CONTROL, 8'h00);
        rdc(ADCC_ADDR_CONTROL, 8'h00);
        chk(8'(converter_power), 8'h00);
        finish_test();
    end
    // Four conversions need under 2000 cycles; allow ten times that.
    initial
    begin
        #1ms;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
